// *** logic/mss_sequencer.sv ***
// Start-up sequencer and phase generator for a six-phase interleaved boost controller.
// Assumes comparator results arrive as synchronous digital levels; APB slave for registers.
// Functional notes
// - Stay off until enable high, then wait for supply POR before leaving first interval.
// - After POR, run an initialisation interval of 60 to 100 us.
// - Assert detection for about 30 us while sampling phase pins.
// - First or second phase pin high during detection latches off until power cycle.
// - After detection wait PLL lock, about 0.5 ms, then start clock forward output.
// - For 50 us after lock, phases tri-level or low, driver enable low.
// - Soft-start ramp starts at the feedback value captured during hold.
// - Soft-start ends at 80% of smaller of tracking reference and internal 2V.
// - Driver enable goes high when the first phase first toggles.
// - Tri-level soft-start: phases alternate tri-level and low only.
// - After tri-level soft-start, phases switch two-level high and low.
// - Mode input high disables phase dropping for the whole run.
// - Light-load mode drops phases by load, never below two.
// - Below two-phase load, turn off synchronous switch at zero current.
// - At deep light load, skip pulses.
// - Two-level mode uses only low and high, duty ramps from zero.
// - Frequency-set fault folds switching back to 75 kHz.
// - Phase switching frequency never exceeds 1 MHz.
// - Sync must be 20% faster than setting; phase one rises on sync edge.
// - Clock forward is 40% high at switching rate, rising with phase one.
// - Phase pins five/six high give four, four gives three, three gives two.
// - Six-phase operation staggers phases by one sixth of a cycle.
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer #(
  parameter int unsigned PLL_LOCK_CYC = mss_pkg::PLL_LOCK_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic enable_in,
  input wire logic supply_por_ok_in,
  input wire logic [5:0] phase_pin_sense_in,
  input wire logic tri_level_sel_in,
  input wire logic mode_high_in,
  input wire logic freq_set_pin_fault_in,
  input wire logic sync_in,
  input wire mss_pkg::mss_load_t load_in,
  output logic [5:0] phase_drive_out,
  output logic [5:0] phase_drive_oe_out,
  output logic [5:0] phase_tri_out,
  output logic sync_switch_en_out,
  output logic driver_enable_out,
  output logic clock_forward_out,
  output logic detect_active_out,
  output logic power_good_flag_out,
  output logic latched_off_out
);

  mss_pkg::mss_state_t state_q;
  logic [31:0] tmr_q;
  logic [15:0] period_q, duty_max_q;
  logic [11:0] feedback_pin_q, tracking_reference_q, ramp_q, ss_target;
  logic soft_en_q;
  logic [15:0] cnt_q, period_eff;
  logic [15:0] duty_q, slot;
  logic [2:0] nphase_q, act_q;
  logic sync_q, pulse_skip_q;
  logic [5:0] drv_d;
  logic [31:0] interval;

  // Interval length of each timed state
  function automatic logic [31:0] interval_of(input mss_pkg::mss_state_t s);
    case (s)
      mss_pkg::ST_INIT: interval_of = 32'(mss_pkg::INIT_CYC);
      mss_pkg::ST_DETECT: interval_of = 32'(mss_pkg::DETECT_CYC);
      mss_pkg::ST_PLL: interval_of = 32'(PLL_LOCK_CYC);
      mss_pkg::ST_HOLD: interval_of = 32'(mss_pkg::HOLD_CYC);
      default: interval_of = 32'h0000_0000;
    endcase
  endfunction : interval_of

  assign interval = interval_of(state_q);

  // Target = 80% of smaller of tracking reference and internal reference
  always_comb begin
    logic [11:0] r;
    r = (tracking_reference_q < mss_pkg::VREF_INT) ? tracking_reference_q : mss_pkg::VREF_INT;
    ss_target = 12'((32'(r) * mss_pkg::POWER_GOOD_FLAG_PCT) / 100);
  end

  // Sequencer
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_q <= mss_pkg::ST_OFF;
      tmr_q <= 32'h0000_0000;
    end else begin
      tmr_q <= tmr_q + 32'h0000_0001;
      case (state_q)
        mss_pkg::ST_OFF: begin
          tmr_q <= 32'h0000_0000;
          if (enable_in && soft_en_q) state_q <= mss_pkg::ST_POR;
        end
        mss_pkg::ST_POR: begin
          tmr_q <= 32'h0000_0000;
          if (!enable_in) state_q <= mss_pkg::ST_OFF;
          else if (supply_por_ok_in) state_q <= mss_pkg::ST_INIT;
        end
        mss_pkg::ST_INIT, mss_pkg::ST_PLL, mss_pkg::ST_HOLD: begin
          if (tmr_q + 32'h0000_0001 >= interval) begin
            tmr_q <= 32'h0000_0000;
            state_q <= mss_pkg::mss_state_t'(state_q + 4'h1);
          end
        end
        mss_pkg::ST_DETECT: begin
          if (phase_pin_sense_in[0] || phase_pin_sense_in[1]) begin
            state_q <= mss_pkg::ST_LATCH;
          end else if (tmr_q + 32'h0000_0001 >= interval) begin
            tmr_q <= 32'h0000_0000;
            state_q <= mss_pkg::ST_PLL;
          end
        end
        mss_pkg::ST_SOFT: begin
          if (ramp_q >= ss_target) state_q <= mss_pkg::ST_RUN;
        end
        mss_pkg::ST_RUN: begin
          if (!enable_in || !soft_en_q) state_q <= mss_pkg::ST_OFF;
        end
        mss_pkg::ST_LATCH: state_q <= mss_pkg::ST_LATCH;
        default: state_q <= mss_pkg::ST_OFF;
      endcase
      if (state_q != mss_pkg::ST_LATCH && state_q != mss_pkg::ST_OFF && !enable_in) begin
        state_q <= mss_pkg::ST_OFF;
      end
    end
  end

  // Phase count from pin straps, sampled during detection
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      nphase_q <= 3'd6;
    end else if (state_q == mss_pkg::ST_DETECT) begin
      if (phase_pin_sense_in[2]) nphase_q <= 3'd2;
      else if (phase_pin_sense_in[3]) nphase_q <= 3'd3;
      else if (phase_pin_sense_in[4] || phase_pin_sense_in[5]) nphase_q <= 3'd4;
      else nphase_q <= 3'd6;
    end
  end

  // Active phases: dropping only in light-load mode, floor of two
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      act_q <= 3'd6;
      pulse_skip_q <= 1'b0;
    end else begin
      if (mode_high_in || state_q != mss_pkg::ST_RUN) begin
        act_q <= nphase_q;
      end else if (load_in.drop_to_two) begin
        act_q <= 3'd2;
      end else if (load_in.drop_to_three && nphase_q > 3'd3) begin
        act_q <= 3'd3;
      end else if (load_in.drop_to_four && nphase_q > 3'd4) begin
        act_q <= 3'd4;
      end else begin
        act_q <= nphase_q;
      end
      pulse_skip_q <= !mode_high_in && state_q == mss_pkg::ST_RUN && load_in.skip_region;
    end
  end

  // Effective period: fold back on fault, clamp to the frequency window
  always_comb begin
    if (freq_set_pin_fault_in) period_eff = 16'(mss_pkg::PERIOD_MAX_CYC);
    else if (period_q < 16'(mss_pkg::PERIOD_MIN_CYC)) period_eff = 16'(mss_pkg::PERIOD_MIN_CYC);
    else if (period_q > 16'(mss_pkg::PERIOD_MAX_CYC)) period_eff = 16'(mss_pkg::PERIOD_MAX_CYC);
    else period_eff = period_q;
    slot = 16'(32'(period_eff) / 32'(act_q));
  end

  // Cycle counter; a sync rising edge restarts phase one only inside the accepted window,
  // so an early edge can never cut a cycle below the shortest period
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= 16'h0000;
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_in;
      if (sync_in && !sync_q && cnt_q + 16'h0001 >= 16'(mss_pkg::PERIOD_MIN_CYC) &&
          (32'(cnt_q) * mss_pkg::SYNC_MARGIN_PCT <= 32'(period_eff) * 100)) begin
        cnt_q <= 16'h0000;
      end else if (cnt_q + 16'h0001 >= period_eff) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // Feedback capture during hold and soft-start ramp; duty ramps from zero
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ramp_q <= 12'h000;
      duty_q <= 16'h0000;
    end else begin
      if (state_q == mss_pkg::ST_HOLD) begin
        ramp_q <= feedback_pin_q;
        duty_q <= 16'h0000;
      end else if (state_q == mss_pkg::ST_SOFT && cnt_q == 16'h0000) begin
        ramp_q <= ramp_q + 12'h001;
        if (duty_q < duty_max_q) duty_q <= duty_q + 16'h0001;
      end else if (state_q == mss_pkg::ST_OFF) begin
        duty_q <= 16'h0000;
      end
    end
  end

  // Per-phase pulse generation
  for (genvar i = 0; i < 6; i++) begin : g_phase
    always_comb begin
      logic [15:0] start, pos;
      start = 16'(32'(slot) * i);
      pos = (cnt_q >= start) ? cnt_q - start : cnt_q + period_eff - start;
      drv_d[i] = (i < act_q) && (pos < duty_q) && !pulse_skip_q;
    end
  end

  // Pin drive, driver enable, clock forward
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      phase_drive_out <= 6'h00;
      phase_drive_oe_out <= 6'h00;
      phase_tri_out <= 6'h00;
      driver_enable_out <= 1'b0;
      clock_forward_out <= 1'b0;
      sync_switch_en_out <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (state_q == mss_pkg::ST_SOFT || state_q == mss_pkg::ST_RUN) begin
          // Inverting drivers: the pulse pulls the pin low to turn the lower switch on
          phase_drive_out[i] <= !drv_d[i];
          if (tri_level_sel_in && (state_q == mss_pkg::ST_SOFT || i >= act_q)) begin
            phase_tri_out[i] <= !drv_d[i];
            phase_drive_oe_out[i] <= drv_d[i];
          end else begin
            phase_tri_out[i] <= 1'b0;
            phase_drive_oe_out[i] <= 1'b1;
          end
        end else begin
          phase_drive_out[i] <= 1'b0;
          phase_tri_out[i] <= tri_level_sel_in;
          phase_drive_oe_out[i] <= !tri_level_sel_in;
        end
      end
      if (state_q == mss_pkg::ST_SOFT && drv_d[0]) driver_enable_out <= 1'b1;
      else if (state_q != mss_pkg::ST_SOFT && state_q != mss_pkg::ST_RUN)
        driver_enable_out <= 1'b0;
      clock_forward_out <= (state_q == mss_pkg::ST_HOLD || state_q == mss_pkg::ST_SOFT ||
                            state_q == mss_pkg::ST_RUN) &&
                           (32'(cnt_q) * 100 < 32'(period_eff) * mss_pkg::CLKFWD_HIGH_PCT);
      sync_switch_en_out <= state_q == mss_pkg::ST_RUN &&
                            !(!mode_high_in && act_q == 3'd2 &&
                              (load_in.diode_region && load_in.zero_current));
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      detect_active_out <= 1'b0;
      power_good_flag_out <= 1'b0;
      latched_off_out <= 1'b0;
    end else begin
      detect_active_out <= state_q == mss_pkg::ST_DETECT;
      power_good_flag_out <= state_q == mss_pkg::ST_RUN;
      latched_off_out <= state_q == mss_pkg::ST_LATCH;
    end
  end

  // APB slave: zero wait states, unmapped reads zero with error
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      soft_en_q <= 1'b1;
      period_q <= mss_pkg::PERIOD_RST;
      duty_max_q <= mss_pkg::DUTY_RST;
      feedback_pin_q <= 12'h000;
      tracking_reference_q <= mss_pkg::VREF_INT;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      if (psel_in && !penable_in) begin
        prdata_out <= 32'h0000_0000;
        case (paddr_in)
          mss_pkg::REG_CTRL: prdata_out <= {31'h0, soft_en_q};
          mss_pkg::REG_PERIOD: prdata_out <= {16'h0, period_q};
          mss_pkg::REG_DUTY: prdata_out <= {16'h0, duty_max_q};
          mss_pkg::REG_STATUS: prdata_out <= {21'h0, act_q, nphase_q, 1'b0, state_q};
          mss_pkg::REG_LOAD: prdata_out <= {16'h0, duty_q};
          mss_pkg::REG_ANALOG: prdata_out <= {4'h0, tracking_reference_q, 4'h0, feedback_pin_q};
          default: pslverr_out <= 1'b1;
        endcase
      end
      // Writes land at the access edge, where the master sees pready high
      if (psel_in && penable_in && pready_out && pwrite_in) begin
        case (paddr_in)
          mss_pkg::REG_CTRL: soft_en_q <= pwdata_in[0];
          mss_pkg::REG_PERIOD: period_q <= pwdata_in[15:0];
          mss_pkg::REG_DUTY: duty_max_q <= pwdata_in[15:0];
          mss_pkg::REG_ANALOG: begin
            feedback_pin_q <= pwdata_in[11:0];
            tracking_reference_q <= pwdata_in[27:16];
          end
          default: ;
        endcase
      end
    end
  end

endmodule : mss_sequencer
`default_nettype wire

// *** logic/mss_pkg.sv ***
// Package for the multiphase start-up sequencer: timing, register map, types.
// Assumes a single 40 MHz system clock.
package mss_pkg;

  localparam int unsigned CLK_HZ = 40000000;
  // Interval lengths in their own units
  localparam int unsigned INIT_US = 80;
  localparam int unsigned DETECT_US = 30;
  localparam int unsigned PLL_LOCK_US = 500;
  localparam int unsigned HOLD_US = 50;
  localparam int unsigned INIT_CYC = INIT_US * (CLK_HZ / 1000000);
  localparam int unsigned DETECT_CYC = DETECT_US * (CLK_HZ / 1000000);
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * (CLK_HZ / 1000000);
  localparam int unsigned HOLD_CYC = HOLD_US * (CLK_HZ / 1000000);
  // Switching frequency limits
  localparam int unsigned FSW_MAX_HZ = 1000000;
  localparam int unsigned FSW_MIN_HZ = 75000;
  localparam int unsigned PERIOD_MIN_CYC = CLK_HZ / FSW_MAX_HZ;
  localparam int unsigned PERIOD_MAX_CYC = CLK_HZ / FSW_MIN_HZ;
  localparam int unsigned SYNC_MARGIN_PCT = 120;
  localparam int unsigned CLKFWD_HIGH_PCT = 40;
  localparam int unsigned POWER_GOOD_FLAG_PCT = 80;
  localparam logic [11:0] VREF_INT = 12'h800;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_DUTY = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_LOAD = 8'h10;
  localparam logic [7:0] REG_ANALOG = 8'h14;
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  localparam logic [15:0] DUTY_RST = 16'h0020;

  // Phase pin drive code
  typedef enum logic [1:0] {PH_LOW, PH_HIGH, PH_TRI} mss_pin_t;

  typedef enum logic [3:0] {
    ST_OFF, ST_POR, ST_INIT, ST_DETECT, ST_PLL, ST_HOLD, ST_SOFT, ST_RUN, ST_LATCH
  } mss_state_t;

  // Load regions reported by the current comparators
  typedef struct packed {
    logic drop_to_four;
    logic drop_to_three;
    logic drop_to_two;
    logic diode_region;
    logic skip_region;
    logic zero_current;
  } mss_load_t;

endpackage : mss_pkg

// *** tb/mss_gate_driver.sv ***
// Behavioural model of the external gate drivers on the six phase outputs.
// Assumes inverting drivers: a low phase level turns the lower switch on.
`timescale 1ns/1ps
`default_nettype none
module mss_gate_driver (
  input wire logic drv_en_in,
  input wire logic [5:0] level_in,
  input wire logic [5:0] tri_in,
  output logic [5:0] lower_on_out,
  output logic [5:0] upper_on_out
);
  // Mid level or a disabled driver keeps both switches off
  assign lower_on_out = drv_en_in ? ~tri_in & ~level_in : 6'h00;
  assign upper_on_out = drv_en_in ? ~tri_in & level_in : 6'h00;
endmodule : mss_gate_driver
`default_nettype wire

// *** tb/mss_checker.sv ***
// Concurrent checks on the start-up sequencer ports.
// Assumes it is bound into the sequencer with the same lock length.
`timescale 1ns/1ps
`default_nettype none
module mss_checker #(
  parameter int unsigned PLL_LOCK_CYC = mss_pkg::PLL_LOCK_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic supply_por_ok_in,
  input wire logic tri_level_sel_in,
  input wire logic [5:0] phase_drive_out,
  input wire logic [5:0] phase_tri_out,
  input wire logic sync_switch_en_out,
  input wire logic driver_enable_out,
  input wire logic detect_active_out,
  input wire logic power_good_flag_out,
  input wire logic latched_off_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  localparam int unsigned INIT_C = mss_pkg::INIT_CYC;
  localparam int unsigned HOLD_C = mss_pkg::HOLD_CYC;
  logic [15:0] on_q, det_q, since_q, gap_q;
  logic [1:0] snap;
  logic p0;
  assign snap = {phase_tri_out[0], phase_drive_out[0]};
  assign p0 = phase_drive_out[0] & ~phase_tri_out[0];
  // Cycle counters since start, within detection, since detection and between pulses
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      on_q <= 16'h0000;
      det_q <= 16'h0000;
      since_q <= 16'hffff;
      gap_q <= 16'hffff;
    end else begin
      on_q <= (enable_in && supply_por_ok_in) ? on_q + {15'h0000, on_q != 16'hffff} : 16'h0000;
      det_q <= detect_active_out ? det_q + 16'h0001 : 16'h0000;
      since_q <= detect_active_out ? 16'h0000 : since_q + {15'h0000, since_q != 16'hffff};
      gap_q <= $rose(p0) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hffff};
    end
  end
  sequence s_det_rise;
    $rose(detect_active_out);
  endsequence
  sequence s_toggle;
    ($past(snap, 2) != snap) or ##1 ($past(snap) != snap);
  endsequence
  property p_init_len;
    s_det_rise |-> on_q >= INIT_C && on_q <= INIT_C + 10;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init interval length wrong");
  property p_det_len;
    $fell(detect_active_out) |-> (det_q == mss_pkg::DETECT_CYC) or ##[0:1] latched_off_out;
  endproperty
  a_det_len: assert property (p_det_len) else $error("detect interval length wrong");
  property p_latch_hold;
    latched_off_out |=> latched_off_out && !driver_enable_out && !power_good_flag_out;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch-off released");
  property p_hold_out;
    since_q >= PLL_LOCK_CYC + 4 && since_q < PLL_LOCK_CYC + HOLD_C - 4 && !latched_off_out
      |-> !driver_enable_out
      && (tri_level_sel_in ? phase_tri_out[1:0] == 2'h3 : phase_drive_out[1:0] == 2'h0);
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("hold interval outputs wrong");
  property p_drv_late;
    $rose(driver_enable_out) |-> since_q >= PLL_LOCK_CYC + HOLD_C
      && since_q <= PLL_LOCK_CYC + HOLD_C + 1100;
  endproperty
  a_drv_late: assert property (p_drv_late) else $error("driver enable at wrong time");
  property p_drv_toggle;
    $rose(driver_enable_out) |-> s_toggle;
  endproperty
  a_drv_toggle: assert property (p_drv_toggle) else $error("driver enable without toggle");
  property p_tri_soft;
    tri_level_sel_in && driver_enable_out && !power_good_flag_out
      |-> !sync_switch_en_out && (phase_drive_out & ~phase_tri_out) == 6'h00;
  endproperty
  a_tri_soft: assert property (p_tri_soft) else $error("phase high in soft-start");
  property p_run_sync;
    $rose(power_good_flag_out) && tri_level_sel_in |-> ##[0:2] sync_switch_en_out;
  endproperty
  a_run_sync: assert property (p_run_sync) else $error("sync switch not allowed in run");
  property p_two_lvl;
    !tri_level_sel_in && driver_enable_out |-> phase_tri_out == 6'h00;
  endproperty
  a_two_lvl: assert property (p_two_lvl) else $error("mid level in two-level mode");
  property p_max_freq;
    $rose(p0) |-> gap_q >= mss_pkg::PERIOD_MIN_CYC - 1;
  endproperty
  a_max_freq: assert property (p_max_freq) else $error("phase pulses too close");
endmodule : mss_checker
`default_nettype wire

// *** tb/tb_mss_sequencer.sv ***
// Testbench for the start-up sequencer: registers, two start-ups and a latch-off.
// Assumes the gate driver model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_mss_sequencer;
  localparam int unsigned PLL_LOCK_CYC = 50;
  logic sys_clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic enable_in = 0, supply_por_ok_in = 0, tri_level_sel_in = 0, mode_high_in = 1;
  logic freq_set_pin_fault_in = 0, sync_in = 0, up_early = 0, e;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, q;
  logic [5:0] phase_pin_sense_in = 6'h00, phase_drive_out, phase_drive_oe_out, phase_tri_out;
  logic [5:0] lower_on, upper_on;
  mss_pkg::mss_load_t load_in = '0;
  logic pready_out, pslverr_out, sync_switch_en_out, driver_enable_out, clock_forward_out;
  logic detect_active_out, power_good_flag_out, latched_off_out;
  logic sync_on = 0;
  logic [6:0] sync_cnt = 7'h00;
  int err_total = 0, check_count = 0, n;
  always #12.5 sys_clk_in = ~sys_clk_in;
  mss_sequencer #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) i_mss_sequencer (.sys_clk_in, .rst_n_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .enable_in, .supply_por_ok_in, .phase_pin_sense_in, .tri_level_sel_in,
    .mode_high_in, .freq_set_pin_fault_in, .sync_in, .load_in, .phase_drive_out,
    .phase_drive_oe_out, .phase_tri_out, .sync_switch_en_out, .driver_enable_out,
    .clock_forward_out, .detect_active_out, .power_good_flag_out, .latched_off_out);
  mss_gate_driver i_mss_gate_driver (.drv_en_in(driver_enable_out), .level_in(phase_drive_out),
    .tri_in(phase_tri_out), .lower_on_out(lower_on), .upper_on_out(upper_on));
  // Upper switch must stay off before power good in tri-level mode
  always @(posedge sys_clk_in) begin
    if (rst_n_in && driver_enable_out === 1'b1 && tri_level_sel_in
        && power_good_flag_out === 1'b0 && upper_on !== 6'h00) begin
      up_early <= 1'b1;
    end
  end
  // External sync source: 80-cycle period, 25% faster than the default setting, 40% high
  always @(posedge sys_clk_in) begin
    sync_cnt <= (sync_cnt == 7'h4f) ? 7'h00 : sync_cnt + 7'h01;
    sync_in <= sync_on && sync_cnt < 7'h20;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic wait_for(ref logic s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (s !== v && cnt < lim) begin
      @(posedge sys_clk_in);
      cnt++;
    end
    if (s !== v) chk("wait limit", {31'h0, v}, {31'h0, s});
  endtask : wait_for
  task automatic reset_dut();
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    enable_in <= 1'b0;
    supply_por_ok_in <= 1'b0;
    load_in <= '0;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
  endtask : reset_dut
  task automatic t_regs();
    apb(1'b0, mss_pkg::REG_CTRL, 32'h0, q, e);
    chk("ctrl", 32'h1, q);
    apb(1'b0, mss_pkg::REG_PERIOD, 32'h0, q, e);
    chk("period", {16'h0, mss_pkg::PERIOD_RST}, q);
    apb(1'b0, mss_pkg::REG_DUTY, 32'h0, q, e);
    chk("duty", {16'h0, mss_pkg::DUTY_RST}, q);
    apb(1'b1, 8'h20, 32'hffff_ffff, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped data", 32'h0, q);
  endtask : t_regs
  task automatic t_start(input logic tri_sel, input logic mh, input logic [5:0] sense,
                         input logic [2:0] n_exp, input logic [2:0] act_exp);
    reset_dut();
    tri_level_sel_in <= tri_sel;
    mode_high_in <= mh;
    phase_pin_sense_in <= sense;
    apb(1'b1, mss_pkg::REG_ANALOG, 32'h0800_0660, q, e);
    enable_in <= 1'b1;
    repeat (100) @(posedge sys_clk_in);
    chk("detect before por", 32'h0, {31'h0, detect_active_out});
    supply_por_ok_in <= 1'b1;
    wait_for(detect_active_out, 1'b1, 5000, n);
    chk("init", 32'h1, {31'h0, n >= mss_pkg::INIT_CYC && n <= mss_pkg::INIT_CYC + 8});
    wait_for(detect_active_out, 1'b0, 5000, n);
    chk("detect", 32'h1, {31'h0, n >= mss_pkg::DETECT_CYC - 2 && n <= mss_pkg::DETECT_CYC + 2});
    wait_for(power_good_flag_out, 1'b1, 20000, n);
    chk("soft start", 32'h1, {31'h0, n >= PLL_LOCK_CYC + mss_pkg::HOLD_CYC
      && n < PLL_LOCK_CYC + mss_pkg::HOLD_CYC + 3000});
    load_in.drop_to_two <= 1'b1;
    repeat (300) @(posedge sys_clk_in);
    chk("driver enable", 32'h1, {31'h0, driver_enable_out});
    if (tri_sel) chk("sync switch", 32'h1, {31'h0, sync_switch_en_out});
    else chk("mid level", 32'h0, {26'h0, phase_tri_out});
    if (!tri_sel) chk("oe two-level", 32'h3f, {26'h0, phase_drive_oe_out});
    apb(1'b0, mss_pkg::REG_STATUS, 32'h0, q, e);
    chk("phase count", {29'h0, n_exp}, {29'h0, q[7:5]});
    chk("active phases", {29'h0, act_exp}, {29'h0, q[10:8]});
  endtask : t_start
  task automatic t_latch();
    reset_dut();
    phase_pin_sense_in <= 6'h02;
    enable_in <= 1'b1;
    supply_por_ok_in <= 1'b1;
    wait_for(latched_off_out, 1'b1, 6000, n);
    enable_in <= 1'b0;
    repeat (20) @(posedge sys_clk_in);
    enable_in <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
    chk("latched", 32'h1, {31'h0, latched_off_out});
    chk("detect latched", 32'h0, {31'h0, detect_active_out});
  endtask : t_latch
  // High time and period of the clock forward output, from one rising edge to the next
  task automatic cf_period(output int hi, output int per);
    wait_for(clock_forward_out, 1'b0, 600, hi);
    wait_for(clock_forward_out, 1'b1, 600, hi);
    wait_for(clock_forward_out, 1'b0, 600, hi);
    wait_for(clock_forward_out, 1'b1, 600, per);
    per = per + hi;
  endtask : cf_period
  task automatic t_run_misc();
    int hi, per, lows;
    cf_period(hi, per);
    chk("clock forward high", mss_pkg::PERIOD_RST * mss_pkg::CLKFWD_HIGH_PCT / 100, hi);
    chk("clock forward period", {16'h0, mss_pkg::PERIOD_RST}, per);
    freq_set_pin_fault_in <= 1'b1;
    cf_period(hi, per);
    chk("foldback period", mss_pkg::PERIOD_MAX_CYC, per);
    freq_set_pin_fault_in <= 1'b0;
    sync_on <= 1'b1;
    repeat (500) @(posedge sys_clk_in);
    cf_period(hi, per);
    chk("sync period", 32'h50, per);
    sync_on <= 1'b0;
    load_in.diode_region <= 1'b1;
    load_in.zero_current <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    chk("diode emulation", 32'h0, {31'h0, sync_switch_en_out});
    load_in.zero_current <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk("sync switch back", 32'h1, {31'h0, sync_switch_en_out});
    load_in.skip_region <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    lows = 0;
    repeat (100) begin
      @(posedge sys_clk_in);
      if (phase_drive_out !== 6'h3f) lows++;
    end
    chk("pulse skip", 32'h0, lows);
    load_in.skip_region <= 1'b0;
    apb(1'b1, mss_pkg::REG_PERIOD, 32'h0000_000a, q, e);
    cf_period(hi, per);
    chk("min period", mss_pkg::PERIOD_MIN_CYC, per);
  endtask : t_run_misc
  task automatic stop_test();
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_start(1'b1, 1'b1, 6'h00, 3'h6, 3'h6);
    chk("upper early", 32'h0, {31'h0, up_early});
    t_start(1'b0, 1'b0, 6'h10, 3'h4, 3'h2);
    t_run_misc();
    t_latch();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge sys_clk_in);
    err_total++;
    stop_test();
  end
endmodule : tb_mss_sequencer
bind mss_sequencer mss_checker #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) i_mss_checker (.sys_clk_in,
  .rst_n_in, .enable_in, .supply_por_ok_in, .tri_level_sel_in, .phase_drive_out,
  .phase_tri_out, .sync_switch_en_out, .driver_enable_out, .detect_active_out,
  .power_good_flag_out, .latched_off_out);
`default_nettype wire
